//--- clock_enable_driver.sv
`timescale 1ns/10ps
// Overview of operation
// - enable logic runs every system clock cycle
// - half rate group shares one enable
// - third rate group has its own enable
// - each clock paired with numbered enable
// - one clock for all; ce_1 high
// - clear input only with clear option
// - data ports pass through unchanged; AXI ports end here
// - companion ce input has no effect
// - extra rates always made by enables
`include "clkdrv_map.svh"

module clock_enable_driver #(
  parameter bit CLEAR_PIN = 1'b1  // clear-pin option present
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              ce_clr,
  output logic                   clk_1,
  output logic                   clk_2,
  output logic                   clk_3,
  output logic                   ce_1,
  output logic                   ce_2,
  output logic                   ce_3,
  input  wire clkdrv_pkg::gw_data_t ext_din,
  output clkdrv_pkg::gw_data_t   core_din,
  input  wire clkdrv_pkg::gw_data_t core_dout,
  output clkdrv_pkg::gw_data_t   ext_dout,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import clkdrv_pkg::*;

  // divisor of each rate, derived from the group periods
  localparam int DIVS [`NUM_RATES] = '{
    1,
    `DIV2_PERIOD_NS / `CLK_PERIOD_NS,
    `DIV3_PERIOD_NS / `CLK_PERIOD_NS};

  logic [1:0]  cnt_reg [`NUM_RATES];  // modulo counters
  logic [1:0]  cnt_next [`NUM_RATES];
  logic        ce_reg [`NUM_RATES];   // registered enables
  logic        sw_clr;                // software clear pulse
  logic        clr;                   // combined counter clear
  logic [31:0] pulse2_reg;            // half rate pulse count
  logic [31:0] pulse3_reg;            // third rate pulse count
  status_t     status;                // live status word

  // every clock output is the system clock itself; slow groups
  // are paced by enables, so no derived clock tree exists
  assign clk_1 = sys_clk;
  assign clk_2 = sys_clk;
  assign clk_3 = sys_clk;

  // enables leave by their divisor suffix, next to their clock
  assign ce_1 = ce_reg[0];
  assign ce_2 = ce_reg[1];
  assign ce_3 = ce_reg[2];

  // the companion ce input is accepted only so the wrapper can
  // sit in a larger design as a black box; it feeds nothing
  logic unused_ce;
  assign unused_ce = ce;

  // the clear pin is ignored when the option is not built in
  assign clr = sw_clr | (CLEAR_PIN & ce_clr);

  // the data ports cross the wrapper untouched; AXI and control inputs end here
  assign core_din = ext_din;
  assign ext_dout = core_dout;

  // one modulo counter per rate, clocked every system cycle;
  // all rates, including any beyond external clock sources,
  // come from here
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_RATES; gi++) begin : g_rate
      localparam logic [1:0] LAST = 2'(DIVS[gi] - 1);
      // wrap at k-1 so the enable holds one cycle in k
      assign cnt_next[gi] = (cnt_reg[gi] == LAST) ?
                            2'h0 : cnt_reg[gi] + 2'h1;
      // no enable gates this process: it runs at full rate
      always_ff @(posedge sys_clk) begin
        if (!rst_n || clr) begin
          cnt_reg[gi] <= 2'h0;
          ce_reg[gi]  <= 1'b1;
        end else begin
          cnt_reg[gi] <= cnt_next[gi];
          ce_reg[gi]  <= (cnt_next[gi] == 2'h0);
        end
      end
    end
  endgenerate

  // pulse counters let software watch the slow groups tick
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pulse2_reg <= `PULSE_RST;
      pulse3_reg <= `PULSE_RST;
    end else begin
      if (ce_2 && !clr)
        pulse2_reg <= pulse2_reg + 32'h1;
      if (ce_3 && !clr)
        pulse3_reg <= pulse3_reg + 32'h1;
    end
  end

  assign status.clr_pin_opt = CLEAR_PIN;
  assign status.ce = {ce_3, ce_2, ce_1};

  // the option flag sits well clear of the enable bits, so more
  // rates can be added below it without moving it
  logic [31:0] stat_word;  // status as laid out on the bus
  assign stat_word = (32'(status.clr_pin_opt) << `STAT_OPT_BIT) |
                     (32'(status.ce) << `STAT_CE_LSB);

  // ---------------- AXI4-Lite write side ----------------
  logic [3:0]  awaddr_reg;   // held write address
  logic        aw_held_reg;  // address taken
  logic [31:0] wdata_reg;    // held write data
  logic        wstrb0_reg;   // low byte lane enabled
  logic        w_held_reg;   // data taken
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        do_write;     // both halves present
  logic        wr_map;       // write address decodes

  // address and data are taken in either order, one write
  // at a time; no new halves until the response is gone
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_map = (awaddr_reg == `CTRL_OFF);
  // the clear bit self-clears: it is a one-cycle command
  assign sw_clr = do_write && wr_map && wstrb0_reg &&
                  wdata_reg[`CTRL_CLR_BIT];
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // capture each half when its handshake completes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awaddr_reg  <= 4'h0;
      aw_held_reg <= 1'b0;
      wdata_reg   <= 32'h0;
      wstrb0_reg  <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
        w_held_reg <= 1'b1;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // response follows both halves; read-only and unmapped
  // addresses answer with an error and change nothing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ---------------- AXI4-Lite read side ----------------
  rd_state_t   rd_state_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_word;   // selected register
  logic        rd_map;    // read address decodes

  assign s_axi_arready = (rd_state_reg == RD_IDLE);
  assign s_axi_rvalid  = (rd_state_reg == RD_VALID);
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ctrl reads zero because its only bit is a command
  assign rd_map = (s_axi_araddr == `CTRL_OFF) ||
                  (s_axi_araddr == `STAT_OFF) ||
                  (s_axi_araddr == `PULSE2_OFF) ||
                  (s_axi_araddr == `PULSE3_OFF);
  assign rd_word =
    (s_axi_araddr == `STAT_OFF)   ? stat_word :
    (s_axi_araddr == `PULSE2_OFF) ? pulse2_reg :
    (s_axi_araddr == `PULSE3_OFF) ? pulse3_reg : 32'h0;

  // data are captured at the address handshake and then held
  // until the master takes them
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_state_reg <= RD_IDLE;
      rdata_reg    <= 32'h0;
      rresp_reg    <= `RESP_OKAY;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_reg <= RD_VALID;
            rdata_reg    <= rd_word;
            rresp_reg    <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        RD_VALID: begin
          if (s_axi_rready)
            rd_state_reg <= RD_IDLE;
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  // ---------------- checks ----------------
  sequence s_quiet3;
    (ce_3 && !clr) ##1 !clr ##1 !clr;
  endsequence

  a_full_rate_high: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ce_1 && $past(ce_1))
    else $error("full rate enable dropped");

  a_half_rate_off: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ce_2 && !clr) |=> !ce_2)
    else $error("half rate enable held two cycles");

  a_half_rate_on: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!ce_2 && !clr) |=> ce_2)
    else $error("half rate enable missed a pulse");

  a_third_rate_gap: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_quiet3 |=> ce_3 && !$past(ce_3) && !$past(ce_3, 2))
    else $error("third rate enable not one in three");

  a_clear_restart: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clr |=> ce_2 && ce_3 && cnt_reg[2] == 2'h0)
    else $error("clear did not restart counters");

  a_clear_pin_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ce_clr && CLEAR_PIN) |=> ce_3 ##1 ($past(clr) || !ce_3))
    else $error("clear pin did not restart third rate");

  a_pass_through: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    core_din == ext_din && ext_dout == core_dout)
    else $error("pass through data altered");

  a_pulse_count: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ce_2 && !clr) |=> pulse2_reg == $past(pulse2_reg) + 32'h1)
    else $error("half rate pulse count missed");

  a_bresp_after_both: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(s_axi_bvalid) |-> $past(aw_held_reg && w_held_reg))
    else $error("write response before both halves");

  a_rdata_holds: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_axi_rvalid && !s_axi_rready) |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  // without the option only software may restart the third rate
  a_pin_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!CLEAR_PIN && !sw_clr && ce_3) |=> !ce_3)
    else $error("clear pin acted without the option");

endmodule

//--- clkdrv_map.svh
`ifndef CLKDRV_MAP_SVH
`define CLKDRV_MAP_SVH

// timing: system period and the two slow group periods, in ns
`define CLK_PERIOD_NS  10
`define DIV2_PERIOD_NS 20
`define DIV3_PERIOD_NS 30
`define NUM_RATES      3

// register byte offsets on the AXI4-Lite slave
`define CTRL_OFF   4'h0
`define STAT_OFF   4'h4
`define PULSE2_OFF 4'h8
`define PULSE3_OFF 4'hc

// field positions
`define CTRL_CLR_BIT  0
`define STAT_CE_LSB   0
`define STAT_OPT_BIT  8

// reset values and responses
`define PULSE_RST   32'h0000_0000
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

//--- clkdrv_pkg.sv
package clkdrv_pkg;
  // data passed through the wrapper unchanged
  typedef logic [2:0] gw_data_t;
  // one enable per rate, bit i divides by i+1
  typedef logic [2:0] ce_vec_t;
  // status word fields
  typedef struct packed {
    logic    clr_pin_opt;
    ce_vec_t ce;
  } status_t;
  // read channel state
  typedef enum logic {RD_IDLE, RD_VALID} rd_state_t;
endpackage

//--- wrapped_logic_model.sv
`timescale 1ns/10ps
// stands in for the wrapped multirate logic; it owns no divider of any kind
module wrapped_logic_model (
  input  wire logic                 clk_1,
  input  wire logic                 clk_2,
  input  wire logic                 ce_1,
  input  wire logic                 ce_2,
  input  wire clkdrv_pkg::gw_data_t din,
  output clkdrv_pkg::gw_data_t      dout
);
  import clkdrv_pkg::*;
  // clk_2 is the system clock itself, paced by ce_2 from outside; nothing here divides it
  gw_data_t hold_reg;  // half-rate input register
  gw_data_t out_reg;   // full-rate stage
  // input register moves only on its paired enable, never on a local count
  always_ff @(posedge clk_2) begin
    if (ce_2) begin
      hold_reg <= din;
    end
  end
  // full-rate stage relies on ce_1 being held high by the driver
  always_ff @(posedge clk_1) begin
    if (ce_1) begin
      out_reg <= hold_reg + 3'h1;
    end
  end
  assign dout = out_reg;
endmodule

//--- testbench.sv
`timescale 1ns/10ps
`include "clkdrv_map.svh"
module testbench;
  import clkdrv_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b0, ce_clr = 1'b0;
  logic clk_1, clk_2, clk_3, ce_1, ce_2, ce_3, n2, n3;
  gw_data_t ext_din = 3'h0, core_din, core_dout, ext_dout;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] c2 = 2'h0, c3 = 2'h0, d2 = 2'h0, d3 = 2'h0;  // expected phases
  logic rnd_clr = 1'b0, force_clr = 1'b0, chk2 = 1'b1;     // stimulus modes
  logic [31:0] p2 = 32'h0, p3 = 32'h0;  // expected pulse counts
  int bad_count = 0;
  int samples_checked = 0;

  clock_enable_driver dut (.*);
  // second driver without the clear option, fed the same pin traffic
  clock_enable_driver #(.CLEAR_PIN(1'b0)) dut2 (.sys_clk, .rst_n, .ce, .ce_clr,
    .clk_1(), .clk_2(), .clk_3(), .ce_1(), .ce_2(n2), .ce_3(n3), .ext_din, .core_din(),
    .core_dout, .ext_dout(), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(),
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);
  wrapped_logic_model partner (.clk_1, .clk_2, .ce_1, .ce_2, .din(core_din), .dout(core_dout));

  always #5 sys_clk = ~sys_clk;  // 100 MHz

  // modulo-k phase; zero means the enable is high
  function automatic logic [1:0] step(input logic [1:0] c, input logic [1:0] k, input logic z);
    return (z || c == k - 2'h1) ? 2'h0 : c + 2'h1;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // both halves offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // random pin traffic; the clear pin is random or commanded
  always @(posedge sys_clk) begin
    ext_din <= gw_data_t'($urandom);
    ce      <= 1'($urandom);
    ce_clr  <= rnd_clr ? ($urandom_range(6) == 0) : force_clr;
  end

  // expected phases; the second driver ignores the pin
  always @(posedge sys_clk) begin
    c2 <= step(c2, 2'h2, !rst_n || ce_clr);
    c3 <= step(c3, 2'h3, !rst_n || ce_clr);
    d2 <= step(d2, 2'h2, !rst_n);
    d3 <= step(d3, 2'h3, !rst_n);
    // a pulse counts only when no clear lands in its cycle
    p2 <= !rst_n ? 32'h0 : p2 + 32'((c2 == 2'h0) && !ce_clr);
    p3 <= !rst_n ? 32'h0 : p3 + 32'((c3 == 2'h0) && !ce_clr);
  end

  // enables and pass-through looked at mid-cycle, when everything has settled
  always @(negedge sys_clk) begin
    check("ce_1", 32'h1, ce_1);
    check("ce_2", c2 == 2'h0, ce_2);
    check("ce_3", c3 == 2'h0, ce_3);
    check("core_din", ext_din, core_din);
    check("ext_dout", core_dout, ext_dout);
    if (chk2) begin
      check("ce_2 no pin", d2 == 2'h0, n2);
      check("ce_3 no pin", d3 == 2'h0, n3);
    end
  end

  // every clock output follows the system clock on both phases
  always @(sys_clk) begin
    #1;
    check("clk_1", sys_clk, clk_1);
    check("clk_2", sys_clk, clk_2);
    check("clk_3", sys_clk, clk_3);
  end

  initial begin
    #100000;
    bad_count++;
    test_done();
  end

  initial begin
    logic [31:0] d, e;
    logic [1:0] r;
    void'($urandom(32'hd1a54457));
    repeat (3) @(posedge sys_clk);
    rst_n   <= 1'b1;
    rnd_clr <= 1'b1;  // ce toggles at random too, with no effect expected
    repeat (300) @(posedge sys_clk);
    rnd_clr   <= 1'b0;
    force_clr <= 1'b1;  // clear held for several cycles back to back
    repeat (4) @(posedge sys_clk);
    force_clr <= 1'b0;
    repeat (20) @(posedge sys_clk);
    // low lane masked: the clear command must not act on either driver
    s_axi_wstrb <= 4'he;
    axi_wr(`CTRL_OFF, 32'h1, r);
    check("masked bresp", `RESP_OKAY, r);
    s_axi_wstrb <= 4'hf;
    // software clear reaches both drivers, so the no-pin model stops here;
    // pin clear is held meanwhile so the first model stays exact
    chk2      <= 1'b0;
    force_clr <= 1'b1;
    axi_wr(`CTRL_OFF, 32'h1, r);
    check("ctrl bresp", `RESP_OKAY, r);
    for (int a = 4; a < 16; a += 4) begin
      axi_wr(4'(a), $urandom, r);
      check("ro bresp", `RESP_SLVERR, r);
    end
    axi_rd(`CTRL_OFF, d, r);
    check("ctrl read", 32'h0, d);
    axi_rd(`STAT_OFF, d, r);
    check("status", 32'h0000_0107, d);
    check("status rresp", `RESP_OKAY, r);
    for (int a = 8; a < 16; a += 4) begin
      axi_rd(4'(a), d, r);
      axi_rd(4'(a), e, r);
      check("pulse count held", d, e);
      check("pulse count", (a == 8) ? p2 : p3, e);
    end
    force_clr <= 1'b0;
    rnd_clr   <= 1'b1;
    repeat (200) @(posedge sys_clk);
    test_done();
  end
endmodule
